// ---- pkg/fst_pkg.sv ----
// package: register map, field layout and shared types for the fifo status block
// Functional notes
// - with fifo mode nonzero, address 0x00 returns the fifo status byte
// - six-bit count reports stored samples, zero empty, up to 32
// - overflow flag stays set while overflow lasts; status read leaves it
// - watermark flag set while count is at or above watermark level
// - in trigger mode the watermark flag reports a trigger event instead
// - status byte read clears the fifo interrupt source bit
// - cleared fifo source bit sets again on next sample if condition active
// - in trigger mode an enabled event flag freezes fifo sample intake while the fifo holds samples
// - trigger register at 0x0a holds five event enables, other bits zero
// - gate error flag sets on gate error, clears only when fifo empties
// - five-bit counter counts rate periods since gate error, zero on clear
// - state field reads 00 standby, 01 wake, resets to standby
// - state field tracks the live device mode for host polling
// - reading the system mode register clears the auto-sleep source bit
// - fifo source bit sets on overflow or watermark event
package fst_pkg;
	localparam logic [7:0] FST_ADDR_STATUS  = 8'h00;
	localparam logic [7:0] FST_ADDR_TRIGSEL = 8'h0a;
	localparam logic [7:0] FST_ADDR_SYSINFO = 8'h0b;
	localparam logic [7:0] FST_TRIG_MASK    = 8'h3e;
	localparam logic [7:0] FST_TRIG_RST     = 8'h00;
	localparam logic [5:0] FST_CNT_RST      = 6'h00;
	localparam logic [5:0] FST_DEPTH        = 6'h20;
	localparam logic [4:0] FST_FGT_RST      = 5'h00;
	localparam logic [4:0] FST_FGT_MAX      = 5'h1f;
	localparam int         FST_EVT_N        = 5;

	typedef enum logic [1:0] {
		FST_MODE_OFF  = 2'b00,
		FST_MODE_CIRC = 2'b01,
		FST_MODE_STOP = 2'b10,
		FST_MODE_TRIG = 2'b11
	} fst_fmode_t;

	typedef enum logic [1:0] {
		FST_SYS_STANDBY = 2'b00,
		FST_SYS_WAKE    = 2'b01,
		FST_SYS_SLEEP   = 2'b10
	} fst_sys_t;

	// event flags: trans, lndprt, pulse, ffmt, a_vecm (bits 4..0)
	typedef struct packed {
		logic       push;
		logic       pop;
		logic       gate_err;
		logic [4:0] evt;
	} fst_evt_t;

	typedef struct packed {
		logic [5:0] cnt;
		logic       ovf;
		logic       trig_hit;
		logic       accept;
		logic       src_fifo;
		logic       src_aslp;
		logic [7:0] trig;
		logic       fgerr;
		logic [4:0] fgt;
		logic [7:0] rdata;
	} fst_state_t;
endpackage : fst_pkg

// ---- src/fst_sync.sv ----
// two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module fst_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// first stage read only by second stage
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : fst_sync

// ---- src/fst_top.sv ----
// fifo status, trigger select and system mode register block
`timescale 1ns/100ps
module fst_top
	import fst_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       reg_rd,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic [7:0] axis_ready_state,
	input  wire logic [1:0] fifo_mode,
	input  wire logic [5:0] fifo_wmrk,
	input  wire logic       sample_tick,
	input  wire logic       fifo_pop,
	input  wire logic       gate_err,
	input  wire logic [4:0] event_flags,
	input  wire logic [1:0] sys_mode,
	input  wire logic       aslp_event,
	output logic      [7:0] reg_rdata,
	output logic            fifo_accept,
	output logic            src_fifo,
	output logic            src_aslp
);
	fst_state_t st_q;
	fst_state_t st_d;
	fst_evt_t   ev;
	logic [4:0] evt_s;
	logic [1:0] sys_s;
	logic       aslp_s;
	logic       frozen;
	logic       wm_cond;
	logic       wm_flag;
	logic       odr_tick;
	logic       rd_status;
	logic       rd_sys;
	logic [7:0] status_b;

	// event flags and mode come from the sample-clock side, resynchronised
	fst_sync #(.W(8)) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.din      ({event_flags, sys_mode, aslp_event}),
		.dout     ({evt_s, sys_s, aslp_s})
	);

	assign ev.evt      = evt_s;
	assign ev.gate_err = gate_err;
	assign ev.pop      = fifo_pop && (st_q.cnt != FST_CNT_RST);
	// intake stops once a trigger has fired in trigger mode
	assign frozen      = (fifo_mode == FST_MODE_TRIG) && st_q.trig_hit;
	assign ev.push     = sample_tick && !frozen && (fifo_mode != FST_MODE_OFF);
	assign odr_tick    = sample_tick;
	assign wm_cond     = (st_q.cnt >= fifo_wmrk);
	assign wm_flag     = (fifo_mode == FST_MODE_TRIG) ? st_q.trig_hit : wm_cond;
	assign status_b    = {st_q.ovf, wm_flag, st_q.cnt};
	assign rd_status   = reg_rd && (reg_addr == FST_ADDR_STATUS) && (fifo_mode != FST_MODE_OFF);
	assign rd_sys      = reg_rd && (reg_addr == FST_ADDR_SYSINFO);

	// next-state logic for the whole block
	always_comb begin
		logic [1:0] sys_code;
		logic       set_fifo;
		logic       wm_next;
		sys_code = 2'b00;
		set_fifo = 1'b0;
		wm_next  = 1'b0;
		st_d     = st_q;
		// sample count: push, pop, or hold at depth and raise overflow in any mode but off, which clears count and overflow
		if (fifo_mode == FST_MODE_OFF) begin
			st_d.cnt = FST_CNT_RST;
			st_d.ovf = 1'b0;
			st_d.trig_hit = 1'b0;
		end else begin
			if (ev.push && !ev.pop) begin
				if (st_q.cnt == FST_DEPTH) begin
					st_d.ovf = 1'b1;
				end else begin
					st_d.cnt = st_q.cnt + 6'h01;
				end
			end else if (ev.pop && !ev.push) begin
				st_d.cnt = st_q.cnt - 6'h01;
				st_d.ovf = 1'b0;
			end
			// any enabled event flag arms the gate in trigger mode
			if ((fifo_mode == FST_MODE_TRIG) && |(ev.evt & st_q.trig[5:1])) begin
				st_d.trig_hit = 1'b1;
			end
			if (st_d.cnt == FST_CNT_RST) begin
				st_d.trig_hit = 1'b0;
			end
		end
		// flag as it stands once this sample has landed, so reaching the level counts
		wm_next = (fifo_mode == FST_MODE_TRIG) ? st_d.trig_hit :
			(st_d.cnt >= fifo_wmrk);
		// interrupt source bit: set on new sample with condition, set beats clear
		if (ev.push && (st_d.ovf || wm_next)) begin
			set_fifo = 1'b1;
		end
		if (rd_status) begin
			st_d.src_fifo = 1'b0;
		end
		if (set_fifo) begin
			st_d.src_fifo = 1'b1;
		end
		if (rd_sys) begin
			st_d.src_aslp = 1'b0;
		end
		if (aslp_s) begin
			st_d.src_aslp = 1'b1;
		end
		// trigger enables, only five bits writable
		if (reg_wr && (reg_addr == FST_ADDR_TRIGSEL)) begin
			st_d.trig = reg_wdata & FST_TRIG_MASK;
		end
		// gate error flag and its age counter
		if (st_d.cnt == FST_CNT_RST) begin
			st_d.fgerr = 1'b0;
			st_d.fgt   = FST_FGT_RST;
		end else begin
			if (ev.gate_err) begin
				st_d.fgerr = 1'b1;
			end
			if (st_q.fgerr && odr_tick && (st_q.fgt != FST_FGT_MAX)) begin
				st_d.fgt = st_q.fgt + 5'h01;
			end
		end
		// live system mode code
		case (sys_s)
			2'b00:   sys_code = FST_SYS_STANDBY;
			2'b01:   sys_code = FST_SYS_WAKE;
			2'b10:   sys_code = FST_SYS_SLEEP;
			default: sys_code = FST_SYS_STANDBY;
		endcase
		// intake gate, kept in the state so the output leaves a flop
		st_d.accept = !((fifo_mode == FST_MODE_TRIG) && st_d.trig_hit);
		// registered read data
		if (reg_rd) begin
			case (reg_addr)
				FST_ADDR_STATUS: st_d.rdata = (fifo_mode != FST_MODE_OFF) ?
					status_b : axis_ready_state;
				FST_ADDR_TRIGSEL: st_d.rdata = st_q.trig;
				FST_ADDR_SYSINFO: st_d.rdata = {st_q.fgerr, st_q.fgt, sys_code};
				default:          st_d.rdata = 8'h00;
			endcase
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '{cnt: FST_CNT_RST, ovf: 1'b0, trig_hit: 1'b0, accept: 1'b0,
				src_fifo: 1'b0, src_aslp: 1'b0, trig: FST_TRIG_RST, fgerr: 1'b0,
				fgt: FST_FGT_RST, rdata: 8'h00};
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata   = st_q.rdata;
	assign fifo_accept = st_q.accept;
	assign src_fifo    = st_q.src_fifo;
	assign src_aslp    = st_q.src_aslp;

	// checks: register reads, sample count and overflow
	// fifo status byte shows the flags and count of the read cycle
	AST_ALIAS: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == FST_ADDR_STATUS && fifo_mode != FST_MODE_OFF)
		|=> reg_rdata == {$past(st_q.ovf), $past(wm_flag), $past(st_q.cnt)})
		else $error("status alias wrong");

	// with the fifo off the same address passes the data-ready byte
	AST_RAW_ALIAS: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == FST_ADDR_STATUS && fifo_mode == FST_MODE_OFF)
		|=> reg_rdata == $past(axis_ready_state))
		else $error("data-ready alias wrong");

	// read data only moves on a read strobe
	AST_RD_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
		!reg_rd
		|=> $stable(reg_rdata))
		else $error("read data moved without a read");

	// count never passes the depth
	AST_CNT_MAX: assert property (@(posedge core_clk) disable iff (!nrst)
		st_q.cnt <= FST_DEPTH)
		else $error("count above depth");

	// a lone push below depth adds one sample
	AST_CNT_UP: assert property (@(posedge core_clk) disable iff (!nrst)
		(ev.push && !ev.pop && st_q.cnt != FST_DEPTH)
		|=> st_q.cnt == $past(st_q.cnt) + 6'h01)
		else $error("count did not rise");

	// a lone pop takes one sample away
	AST_CNT_DN: assert property (@(posedge core_clk) disable iff (!nrst)
		(ev.pop && !ev.push && fifo_mode != FST_MODE_OFF)
		|=> st_q.cnt == $past(st_q.cnt) - 6'h01)
		else $error("count did not fall");

	// a push into a full fifo raises overflow
	AST_OVF_SET: assert property (@(posedge core_clk) disable iff (!nrst)
		(ev.push && !ev.pop && st_q.cnt == FST_DEPTH)
		|=> st_q.ovf)
		else $error("overflow not raised");

	// overflow stays while nothing drains, reads included
	AST_OVF_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
		(st_q.ovf && !fifo_pop && fifo_mode != FST_MODE_OFF)
		|=> st_q.ovf)
		else $error("overflow dropped");

	// watermark bit of a read byte is high at or above the level
	AST_WMRK: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == FST_ADDR_STATUS && fifo_mode != FST_MODE_OFF &&
		fifo_mode != FST_MODE_TRIG && st_q.cnt >= fifo_wmrk) |=> reg_rdata[6])
		else $error("watermark flag low");

	// in trigger mode the same bit reports the trigger
	AST_TRIG_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == FST_ADDR_STATUS && fifo_mode == FST_MODE_TRIG)
		|=> reg_rdata[6] == $past(st_q.trig_hit))
		else $error("trigger flag wrong");

	// checks: interrupt source bits
	// status read clears the fifo source bit when no sample sets it
	AST_RDCLR: assert property (@(posedge core_clk) disable iff (!nrst)
		(rd_status && !sample_tick)
		|=> !src_fifo)
		else $error("src fifo not cleared");

	// a new sample with the watermark still met sets the bit again
	AST_SRC_WM: assert property (@(posedge core_clk) disable iff (!nrst)
		(ev.push && fifo_mode != FST_MODE_TRIG && st_q.cnt >= fifo_wmrk)
		|=> src_fifo)
		else $error("src fifo not set on watermark");

	// an overflowing sample sets the bit
	AST_SRC_OVF: assert property (@(posedge core_clk) disable iff (!nrst)
		(ev.push && !ev.pop && st_q.cnt == FST_DEPTH)
		|=> src_fifo)
		else $error("src fifo not set on overflow");

	// checks: trigger gate and enable register
	// no sample enters while the gate is shut
	AST_FREEZE: assert property (@(posedge core_clk) disable iff (!nrst)
		(frozen && !fifo_pop)
		|=> st_q.cnt == $past(st_q.cnt))
		else $error("fifo moved while frozen");

	// intake output drops once a trigger has fired in trigger mode
	AST_ACCEPT: assert property (@(posedge core_clk) disable iff (!nrst)
		($past(fifo_mode) == FST_MODE_TRIG && st_q.trig_hit)
		|-> !fifo_accept)
		else $error("intake still open after trigger");

	// only the five enables can hold a one
	AST_TRIG_MASK: assert property (@(posedge core_clk) disable iff (!nrst)
		(st_q.trig & ~FST_TRIG_MASK) == 8'h00)
		else $error("unused trigger bit set");

	// a write keeps the enable bits it carries
	AST_TRIG_WR: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_wr && reg_addr == FST_ADDR_TRIGSEL)
		|=> st_q.trig == ($past(reg_wdata) & FST_TRIG_MASK))
		else $error("trigger enables not written");

	// a read of the enables shows the unused bits as zero
	AST_TRIG_RD: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == FST_ADDR_TRIGSEL)
		|=> (reg_rdata & ~FST_TRIG_MASK) == 8'h00)
		else $error("unused trigger bit read as one");

	// checks: gate error and its age
	// a gate error with samples held raises the flag
	AST_FGERR_SET: assert property (@(posedge core_clk) disable iff (!nrst)
		(gate_err && !fifo_pop && fifo_mode != FST_MODE_OFF && st_q.cnt != FST_CNT_RST)
		|=> st_q.fgerr)
		else $error("gate error not flagged");

	// the flag only falls when the fifo empties
	AST_FGERR_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
		(st_q.fgerr && !fifo_pop && fifo_mode != FST_MODE_OFF)
		|=> st_q.fgerr)
		else $error("gate error dropped early");

	// an empty fifo carries no gate error and no age
	AST_FGERR_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
		(st_q.cnt == FST_CNT_RST)
		|-> (!st_q.fgerr && st_q.fgt == FST_FGT_RST))
		else $error("gate error with empty fifo");

	// age stays zero while no gate error stands
	AST_FGT_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
		!st_q.fgerr
		|-> st_q.fgt == FST_FGT_RST)
		else $error("age counter nonzero");

	// age steps once per rate period while the error stands
	AST_FGT_STEP: assert property (@(posedge core_clk) disable iff (!nrst)
		(st_q.fgerr && sample_tick && !fifo_pop && fifo_mode != FST_MODE_OFF &&
		st_q.fgt != FST_FGT_MAX) |=> st_q.fgt == $past(st_q.fgt) + 5'h01)
		else $error("age counter did not step");

	// checks: system mode register
	// mode code follows the live mode, the spare code reads standby
	AST_SYS_CODE: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == FST_ADDR_SYSINFO)
		|=> reg_rdata[1:0] == (($past(sys_s) == 2'b11) ? 2'b00 : $past(sys_s)))
		else $error("mode code wrong");

	// upper bits carry the gate error flag and its age
	AST_SYS_FIELDS: assert property (@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == FST_ADDR_SYSINFO)
		|=> reg_rdata[7:2] == {$past(st_q.fgerr), $past(st_q.fgt)})
		else $error("gate error fields wrong");

	// mode register read clears the sleep source bit
	AST_ASLP: assert property (@(posedge core_clk) disable iff (!nrst)
		(rd_sys && !aslp_s)
		|=> !src_aslp)
		else $error("src aslp not cleared");

	// a sleep or wake event sets the source bit
	AST_ASLP_SET: assert property (@(posedge core_clk) disable iff (!nrst)
		aslp_s
		|=> src_aslp)
		else $error("src aslp not set");
endmodule : fst_top

// ---- tb/fst_host_model.sv ----
// host model: issues register reads and writes on the serial-port side
`timescale 1ns/100ps
module fst_host_model (
	input  wire logic       core_clk,
	output logic            reg_rd,
	output logic            reg_wr,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	initial begin
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_addr  = 8'h55;
		reg_wdata = 8'haa;
	end

	// one-cycle read strobe, address flipped once released
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk) #1;
		reg_rd   = 1'b1;
		reg_addr = a;
		@(posedge core_clk) #1;
		reg_rd   = 1'b0;
		reg_addr = ~a;
	endtask : rd

	// one-cycle write strobe, data flipped once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(posedge core_clk) #1;
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~d;
	endtask : wr
endmodule : fst_host_model

// ---- tb/tb_fst_top.sv ----
// self-checking testbench for the fifo status block
`timescale 1ns/100ps
module tb_fst_top;
	import fst_pkg::*;
	logic core_clk = 0, nrst = 0, tck = 0, pop = 0, gerr = 0, aev = 0, pend = 0;
	logic [7:0] ars = 8'h0b, rdata, rnd = 8'h0b;
	logic [1:0] fmode = 2'b00, smode = 2'b00;
	logic [5:0] wmrk = 6'h03;
	logic [4:0] evf = 5'h00;
	logic       rd, wr, acc, sfifo, saslp;
	logic [7:0] addr, wdat;
	logic [7:0] q[$];
	int         error_cnt = 0, checks = 0;

	always #2 core_clk = ~core_clk;
	fst_host_model u_host (.core_clk(core_clk), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
		.reg_wdata(wdat));
	fst_top u_dut (.core_clk(core_clk), .nrst(nrst), .reg_rd(rd), .reg_wr(wr),
		.reg_addr(addr), .reg_wdata(wdat), .axis_ready_state(ars), .fifo_mode(fmode),
		.fifo_wmrk(wmrk), .sample_tick(tck), .fifo_pop(pop), .gate_err(gerr),
		.event_flags(evf), .sys_mode(smode), .aslp_event(aev), .reg_rdata(rdata),
		.fifo_accept(acc), .src_fifo(sfifo), .src_aslp(saslp));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// read with the expected byte noted for the watcher
	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		u_host.rd(a);
	endtask : rdx

	// hold one strobe high for n cycles: 0 tick, 1 pop, 2 gate error, 3 sleep event
	task automatic strobe(input int w, input int n);
		repeat (n) begin
			@(posedge core_clk) #1;
			{aev, gerr, pop, tck} = 4'b0001 << w;
		end
		@(posedge core_clk) #1;
		{aev, gerr, pop, tck} = 4'b0000;
	endtask : strobe

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : idle

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	// watcher: read data lands one cycle after the strobe
	always @(posedge core_clk) pend <= rd;
	always @(negedge core_clk) begin
		if (pend) begin
			if (q.size() == 0) chk(8'hxx, 8'h00);
			else chk(rdata, q.pop_front());
		end
	end

	initial begin
		#20000;
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (3) rnd = lfsr(rnd);
		repeat (20) @(posedge core_clk);
		#1 nrst = 1'b1;
		ars = rnd;
		rdx(FST_ADDR_STATUS, rnd);
		rdx(FST_ADDR_SYSINFO, 8'h00);
		rdx(FST_ADDR_TRIGSEL, 8'h00);
		u_host.wr(FST_ADDR_TRIGSEL, 8'hff);
		rdx(FST_ADDR_TRIGSEL, 8'h3e);
		rdx(8'h05, 8'h00);
		$display("test registers done");
		fmode = FST_MODE_CIRC;
		strobe(0, 3);
		idle(1);
		chk(sfifo, 8'h01);
		rdx(FST_ADDR_STATUS, 8'h43);
		idle(1);
		chk(sfifo, 8'h00);
		strobe(0, 1);
		idle(1);
		chk(sfifo, 8'h01);
		strobe(2, 1);
		strobe(0, 2);
		rdx(FST_ADDR_SYSINFO, 8'h88);
		strobe(1, 7);
		rdx(FST_ADDR_SYSINFO, 8'h00);
		strobe(0, 33);
		rdx(FST_ADDR_STATUS, 8'he0);
		rdx(FST_ADDR_STATUS, 8'he0);
		strobe(1, 1);
		rdx(FST_ADDR_STATUS, 8'h5f);
		strobe(1, 31);
		$display("test fifo status done");
		smode = FST_SYS_WAKE;
		idle(4);
		rdx(FST_ADDR_SYSINFO, 8'h01);
		smode = FST_SYS_SLEEP;
		strobe(3, 1);
		idle(4);
		chk(saslp, 8'h01);
		rdx(FST_ADDR_SYSINFO, 8'h02);
		idle(1);
		chk(saslp, 8'h00);
		$display("test system mode done");
		fmode = FST_MODE_TRIG;
		u_host.wr(FST_ADDR_TRIGSEL, 8'h02);
		strobe(0, 1);
		chk(acc, 8'h01);
		evf = 5'h01;
		idle(5);
		chk(acc, 8'h00);
		strobe(0, 2);
		rdx(FST_ADDR_STATUS, 8'h41);
		idle(3);
		$display("test trigger done");
		finish_test();
	end
endmodule : tb_fst_top
